// ===== rtac_remote_alias.sv
// Notes on behaviour
// - Address, alias, counter registers exist per port
// - Second-port select reads port 1 counter
// - Alias field decodes local transactions for remote
// - Zero alias forwards nothing
// - Matched address replaced by physical target address
// - Setup field sets ack SDA lead during remote access
// - Setup 80 ns plus 640 ns per unit
// - Counter low byte read-only at low register
// - Counter high byte read-only at next register
// - Counter cleared only by CRC error reset or by reset_n
module rtac_remote_alias
  import rtac_pkg::*;
#(
  parameter int PORTS = 2,
  parameter int CNT_WIDTH = 16,
  parameter int SETUP_WIDTH = 10
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Register access from the local serial control slave
  input wire rtac_reg_req_s regReq,
  output logic [7:0] regRdata,
  // Controls held in neighbouring registers
  input wire logic secondPortSelect,
  input wire logic crcErrorReset,
  // Back-channel CRC error pulses, one per port
  input wire logic [PORTS-1:0] crcError,
  // Local transaction address to decode
  input wire rtac_xact_s xact,
  input wire logic remoteAccessActive,
  // Forwarding decision
  output logic fwdValid,
  output logic [PORTS-1:0] fwdHit,
  output logic [PORTS-1:0][6:0] fwdPhysAddr,
  // Ack setup time in clock cycles, zero when idle
  output logic [SETUP_WIDTH-1:0] ackSetupCycles
);

  logic [PORTS-1:0][7:0] tgtAddr;
  logic [PORTS-1:0][6:0] tgtAlias;
  logic [3:0] sdaSetup;
  logic [PORTS-1:0][CNT_WIDTH-1:0] crcCount;
  logic [PORTS-1:0][7:0] next_tgtAddr;
  logic [PORTS-1:0][6:0] next_tgtAlias;
  logic [3:0] next_sdaSetup;
  logic [7:0] next_regRdata;
  logic next_fwdValid;
  logic [PORTS-1:0] next_fwdHit;
  logic [PORTS-1:0][6:0] next_fwdPhysAddr;
  logic [SETUP_WIDTH-1:0] next_ackSetupCycles;
  logic portIdx;
  logic [SETUP_WIDTH-1:0] setupCalc;

  assign portIdx = secondPortSelect;

  for (genvar p = 0; p < PORTS; p++) begin : gCrc
    rtac_crc_counter #(.WIDTH(CNT_WIDTH)) uCount (
      .clock(clock),
      .reset_n(reset_n),
      .crcError(crcError[p]),
      .clear(crcErrorReset),
      .count(crcCount[p])
    );
  end

  // Register writes; counter registers ignore writes
  always_comb begin
    next_tgtAddr = tgtAddr;
    next_tgtAlias = tgtAlias;
    next_sdaSetup = sdaSetup;
    if (regReq.write) begin
      case (regReq.addr)
        OFF_TGT_ADDR: next_tgtAddr[portIdx] = regReq.wdata;
        OFF_TGT_ALIAS: next_tgtAlias[portIdx] =
          regReq.wdata[7:ADDR_FIELD_LSB];
        OFF_SDA_SETUP: next_sdaSetup =
          regReq.wdata[SETUP_FIELD_MSB:0];
        default: ;
      endcase
    end
  end

  // Read data, captured on the read strobe; reading never clears
  always_comb begin
    next_regRdata = regRdata;
    if (regReq.read) begin
      case (regReq.addr)
        OFF_TGT_ADDR: next_regRdata = tgtAddr[portIdx];
        OFF_TGT_ALIAS: next_regRdata = {tgtAlias[portIdx], 1'b0};
        OFF_SDA_SETUP: next_regRdata = {4'h0, sdaSetup};
        OFF_CRC_LOW: next_regRdata = crcCount[portIdx][7:0];
        OFF_CRC_HIGH: next_regRdata = crcCount[portIdx][15:8];
        default: next_regRdata = 8'h00;
      endcase
    end
  end

  // Alias decode and remap, checked against every port's copy
  always_comb begin
    next_fwdValid = xact.valid;
    next_fwdHit = '0;
    next_fwdPhysAddr = fwdPhysAddr;
    for (int p = 0; p < PORTS; p++) begin
      if (xact.valid && tgtAlias[p] != 7'h00
          && xact.addr == tgtAlias[p]) begin
        next_fwdHit[p] = 1'b1;
        next_fwdPhysAddr[p] = tgtAddr[p][7:ADDR_FIELD_LSB];
      end
    end
  end

  // Rounded down from ns; the step is an exact cycle multiple at 100 MHz
  assign setupCalc = SETUP_WIDTH'(SETUP_BASE_CYC)
    + SETUP_WIDTH'(SETUP_STEP_CYC) * SETUP_WIDTH'(sdaSetup);

  always_comb begin
    next_ackSetupCycles = '0;
    if (remoteAccessActive) begin
      next_ackSetupCycles = setupCalc;
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      tgtAddr <= {PORTS{RST_TGT_ADDR}};
      tgtAlias <= {PORTS{RST_TGT_ALIAS}};
      sdaSetup <= RST_SDA_SETUP;
      regRdata <= 8'h00;
      fwdValid <= 1'b0;
      fwdHit <= '0;
      fwdPhysAddr <= '0;
      ackSetupCycles <= '0;
    end else begin
      tgtAddr <= next_tgtAddr;
      tgtAlias <= next_tgtAlias;
      sdaSetup <= next_sdaSetup;
      regRdata <= next_regRdata;
      fwdValid <= next_fwdValid;
      fwdHit <= next_fwdHit;
      fwdPhysAddr <= next_fwdPhysAddr;
      ackSetupCycles <= next_ackSetupCycles;
    end
  end

  a_alias_hit: assert property (@(posedge clock) disable iff (!reset_n)
    xact.valid && tgtAlias[0] != 7'h00 && xact.addr == tgtAlias[0]
    |=> fwdHit[0] && fwdValid)
    else $error("alias match not flagged");

  a_zero_alias: assert property (@(posedge clock) disable iff (!reset_n)
    fwdHit[1] |-> $past(tgtAlias[1]) != 7'h00)
    else $error("forwarded with zero alias");

  a_remap_addr: assert property (@(posedge clock) disable iff (!reset_n)
    fwdHit[0] |-> fwdPhysAddr[0] == $past(tgtAddr[0][7:1]))
    else $error("remapped address wrong");

  a_setup_time: assert property (@(posedge clock) disable iff (!reset_n)
    remoteAccessActive
    |=> ackSetupCycles == 10'(8 + 64 * $past(sdaSetup)))
    else $error("ack setup cycles wrong");

  a_setup_idle: assert property (@(posedge clock) disable iff (!reset_n)
    !remoteAccessActive |=> ackSetupCycles == '0)
    else $error("ack setup driven while idle");

  a_crc_port1: assert property (@(posedge clock) disable iff (!reset_n)
    regReq.read && regReq.addr == OFF_CRC_LOW && secondPortSelect
    |=> regRdata == $past(crcCount[1][7:0]))
    else $error("port 1 counter not returned");

  a_crc_high: assert property (@(posedge clock) disable iff (!reset_n)
    regReq.read && regReq.addr == OFF_CRC_HIGH && !secondPortSelect
    |=> regRdata == $past(crcCount[0][15:8]))
    else $error("counter high byte wrong");

  a_port_write: assert property (@(posedge clock) disable iff (!reset_n)
    regReq.write && regReq.addr == OFF_TGT_ALIAS && secondPortSelect
    |=> tgtAlias[1] == $past(regReq.wdata[7:1])
        && tgtAlias[0] == $past(tgtAlias[0]))
    else $error("alias write reached wrong port");

  a_crc_readonly: assert property (@(posedge clock) disable iff (!reset_n)
    regReq.write && regReq.addr == OFF_CRC_LOW && !crcErrorReset
    && crcError == '0 |=> crcCount == $past(crcCount))
    else $error("counter changed by write");

  a_alias_hit1: assert property (@(posedge clock) disable iff (!reset_n)
    xact.valid && tgtAlias[1] != 7'h00 && xact.addr == tgtAlias[1]
    |=> fwdHit[1] && fwdValid)
    else $error("port 1 alias match not flagged");

  a_zero_alias0: assert property (@(posedge clock) disable iff (!reset_n)
    fwdHit[0] |-> $past(tgtAlias[0]) != 7'h00)
    else $error("forwarded with zero alias on port 0");

  a_remap_addr1: assert property (@(posedge clock) disable iff (!reset_n)
    fwdHit[1] |-> fwdPhysAddr[1] == $past(tgtAddr[1][7:1]))
    else $error("port 1 remapped address wrong");

  a_tgt_write: assert property (@(posedge clock) disable iff (!reset_n)
    regReq.write && regReq.addr == OFF_TGT_ADDR && !secondPortSelect
    |=> tgtAddr[0] == $past(regReq.wdata))
    else $error("target address write lost");

  a_setup_write: assert property (@(posedge clock) disable iff (!reset_n)
    regReq.write && regReq.addr == OFF_SDA_SETUP
    |=> sdaSetup == $past(regReq.wdata[3:0]))
    else $error("setup field write lost");

  a_crc_low: assert property (@(posedge clock) disable iff (!reset_n)
    regReq.read && regReq.addr == OFF_CRC_LOW && !secondPortSelect
    |=> regRdata == $past(crcCount[0][7:0]))
    else $error("counter low byte wrong");

  a_crc_high1: assert property (@(posedge clock) disable iff (!reset_n)
    regReq.read && regReq.addr == OFF_CRC_HIGH && secondPortSelect
    |=> regRdata == $past(crcCount[1][15:8]))
    else $error("port 1 counter high byte wrong");

  a_read_noclear: assert property (@(posedge clock) disable iff (!reset_n)
    regReq.read && !crcErrorReset && crcError == '0
    |=> crcCount == $past(crcCount))
    else $error("counter changed by read");

endmodule

// ===== rtac_pkg.sv
package rtac_pkg;

  // Register offsets; the SDA setup register is shared, the rest are per port
  localparam logic [7:0] OFF_TGT_ADDR = 8'h07;
  localparam logic [7:0] OFF_TGT_ALIAS = 8'h08;
  localparam logic [7:0] OFF_SDA_SETUP = 8'h09;
  localparam logic [7:0] OFF_CRC_LOW = 8'h0A;
  localparam logic [7:0] OFF_CRC_HIGH = 8'h0B;

  // Field positions
  localparam int ADDR_FIELD_LSB = 1;
  localparam int SETUP_FIELD_MSB = 3;

  // Reset values
  localparam logic [7:0] RST_TGT_ADDR = 8'h00;
  localparam logic [6:0] RST_TGT_ALIAS = 7'h00;
  localparam logic [3:0] RST_SDA_SETUP = 4'h1;
  localparam logic [15:0] RST_CRC_COUNT = 16'h0000;

  // Ack setup timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int SETUP_BASE_NS = 80;
  localparam int SETUP_STEP_NS = 640;
  localparam int SETUP_BASE_CYC = SETUP_BASE_NS / CLK_PERIOD_NS;
  localparam int SETUP_STEP_CYC = SETUP_STEP_NS / CLK_PERIOD_NS;

  typedef struct packed {
    logic read;
    logic write;
    logic [7:0] addr;
    logic [7:0] wdata;
  } rtac_reg_req_s;

  typedef struct packed {
    logic valid;
    logic [6:0] addr;
  } rtac_xact_s;

endpackage

// ===== rtac_crc_counter.sv
module rtac_crc_counter
  import rtac_pkg::*;
#(
  parameter int WIDTH = 16
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Events and clear
  input wire logic crcError,
  input wire logic clear,
  // Count
  output logic [WIDTH-1:0] count
);

  logic [WIDTH-1:0] next_count;

  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = '0;
    end else if (crcError && count != {WIDTH{1'b1}}) begin
      // Saturate so software never sees a wrapped small value
      next_count = count + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count <= RST_CRC_COUNT[WIDTH-1:0];
    end else begin
      count <= next_count;
    end
  end

  a_count_clear: assert property (@(posedge clock) disable iff (!reset_n)
    clear |=> count == '0)
    else $error("counter not cleared");

  a_count_step: assert property (@(posedge clock) disable iff (!reset_n)
    crcError && !clear && count != {WIDTH{1'b1}}
    |=> count == $past(count) + 1'b1)
    else $error("counter did not step by one");

  a_count_hold: assert property (@(posedge clock) disable iff (!reset_n)
    !clear && (!crcError || count == {WIDTH{1'b1}})
    |=> count == $past(count))
    else $error("counter changed without cause");

endmodule

// ===== rtac_host.sv
module rtac_host
  import rtac_pkg::*;
(
  // Clock
  input wire logic clock,
  // Register requests
  output rtac_reg_req_s regReq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] expQ[$];
  initial regReq = '0;
  // One-cycle strobe, then a quiet cycle before the next one
  task automatic access(input logic w, input logic [7:0] a, d);
    @(negedge clock);
    regReq <= '{read: !w, write: w, addr: a, wdata: d};
    @(negedge clock);
    regReq <= '0;
  endtask
  task automatic rd(input logic [7:0] a, e);
    expQ.push_back(e);
    access(1'b0, a, 8'h00);
  endtask
endmodule

// ===== rtac_remote_alias_tb_top.sv
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
  $display("BAD %s exp %h got %h", n, e, g); n_errors++; end end
module rtac_remote_alias_tb_top
  import rtac_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock, reset_n, secondPortSelect, crcErrorReset, remoteAccessActive;
  logic fwdValid, rdTaken;
  logic [1:0] crcError, fwdHit, h;
  logic [1:0][6:0] fwdPhysAddr;
  logic [7:0] regRdata, d, e;
  logic [9:0] ackSetupCycles;
  logic [6:0] tgt[2], ali[2];
  logic [1:0] fwdQ[$];
  logic [31:0] seed = 32'h62;
  rtac_reg_req_s regReq;
  rtac_xact_s xact;
  int n_errors = 0;
  int comparisons = 0;
  rtac_remote_alias rtac_remote_alias_i(.clock(clock), .reset_n(reset_n),
    .regReq(regReq), .regRdata(regRdata),
    .secondPortSelect(secondPortSelect), .crcErrorReset(crcErrorReset),
    .crcError(crcError), .xact(xact), .remoteAccessActive(remoteAccessActive),
    .fwdValid(fwdValid), .fwdHit(fwdHit), .fwdPhysAddr(fwdPhysAddr),
    .ackSetupCycles(ackSetupCycles));
  rtac_host rtac_host_i(.clock(clock), .regReq(regReq));
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic give_verdict();
    $display("Counts: %0d compared, %0d bad", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic wr(input logic p, input logic [7:0] a, v);
    secondPortSelect <= p;
    rtac_host_i.access(1'b1, a, v);
  endtask
  task automatic rd(input logic p, input logic [7:0] a, v);
    secondPortSelect <= p;
    rtac_host_i.rd(a, v);
  endtask
  task automatic xa(input logic [6:0] a);
    fwdQ.push_back({a == ali[1] && ali[1] != 0, a == ali[0] && ali[0] != 0});
    @(negedge clock);
    xact <= '{valid: 1'b1, addr: a};
    @(negedge clock);
    xact <= '0;
  endtask
  initial begin
    clock = 0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) rdTaken <= regReq.read;
  always @(negedge clock) begin
    if (rdTaken) begin
      e = rtac_host_i.expQ.pop_front();
      `CHK("regRdata", e, regRdata)
    end
    if (fwdValid) begin
      h = fwdQ.pop_front();
      `CHK("fwdHit", h, fwdHit)
      for (int p = 0; p < 2; p++)
        if (h[p]) `CHK("fwdPhysAddr", tgt[p], fwdPhysAddr[p])
    end
  end
  initial begin
    repeat (100000) @(posedge clock);
    n_errors++;
    give_verdict();
  end
  initial begin
    {reset_n, secondPortSelect, crcErrorReset, remoteAccessActive} = '0;
    crcError = '0;
    xact = '0;
    repeat (6) @(posedge clock);
    @(negedge clock) reset_n = 1;
    for (int p = 0; p < 2; p++)
      for (int a = 7; a < 12; a++)
        rd(p[0], 8'(a), a == 9 ? 8'h01 : 8'h00);
    $display("Test reset values done");
    for (int p = 0; p < 2; p++) begin
      d = rnd();
      tgt[p] = d[7:1];
      wr(p[0], 8'h07, d);
      rd(p[0], 8'h07, d);
      d = rnd() | 8'h03;
      ali[p] = d[7:1];
      wr(p[0], 8'h08, d);
      rd(p[0], 8'h08, {d[7:1], 1'b0});
    end
    for (int p = 0; p < 2; p++) xa(ali[p]);
    wr(1'b1, 8'h08, 8'h00);
    ali[1] = 7'h00;
    xa(7'h00);
    xa(ali[0]);
    $display("Test alias decode done");
    d = rnd();
    wr(1'b0, 8'h09, d);
    rd(1'b0, 8'h09, {4'h0, d[3:0]});
    @(negedge clock) remoteAccessActive = 1;
    repeat (2) @(negedge clock);
    `CHK("ackSetup", 10'(8 + 64 * d[3:0]), ackSetupCycles)
    remoteAccessActive = 0;
    repeat (2) @(negedge clock);
    `CHK("ackSetupIdle", 10'h000, ackSetupCycles)
    $display("Test ack setup done");
    crcError = 2'b11;
    repeat (3) @(negedge clock);
    crcError = 2'b01;
    repeat (2) @(negedge clock);
    crcError = 2'b00;
    wr(1'b0, 8'h0A, 8'h55);
    wr(1'b0, 8'h0B, 8'h55);
    rd(1'b0, 8'h0A, 8'h05);
    rd(1'b1, 8'h0A, 8'h03);
    rd(1'b0, 8'h0A, 8'h05);
    rd(1'b0, 8'h0B, 8'h00);
    rd(1'b0, 8'h0C, 8'h00);
    @(negedge clock) crcErrorReset = 1;
    @(negedge clock) crcErrorReset = 0;
    rd(1'b0, 8'h0A, 8'h00);
    rd(1'b1, 8'h0A, 8'h00);
    crcError = 2'b01;
    repeat (65540) @(negedge clock);
    crcError = 2'b00;
    rd(1'b0, 8'h0A, 8'hFF);
    rd(1'b0, 8'h0B, 8'hFF);
    rd(1'b1, 8'h0B, 8'h00);
    $display("Test error counter done");
    repeat (3) @(negedge clock);
    `CHK("pending", 0, rtac_host_i.expQ.size() + fwdQ.size())
    give_verdict();
  end
endmodule
